// ==== rtl/ccs_defs.svh ====
// Purpose: Offsets, field positions, reset values and counts of the CPU clock select block
// Assumes: sys_clk is the main oscillator clock
// Notes:   Register offsets are word indices; byte address is four times the index
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// Register indices
`define CCS_IDX_DIV 12'hfb3
`define CCS_IDX_SRC 12'hfb7
`define CCS_IDX_STAT 12'hfb8
`define CCS_IDX_SOS 12'hfcf

// Field positions
`define CCS_SOS_RES_OFF_BIT 0
`define CCS_SOS_HV_BIT 1

// Reset values
`define CCS_DIV_RST 2'h0
`define CCS_SOS_RST 2'h0

// Divider period minus one, in main oscillator cycles
`define CCS_LIM_DIV64 6'h3f
`define CCS_LIM_DIV16 6'h0f
`define CCS_LIM_DIV8 6'h07
`define CCS_LIM_DIV4 6'h03
// Subsystem clock: CPU period of four subsystem edges
`define CCS_LIM_SUB 6'h03

// Stabilization time in main oscillator periods
`define CCS_STAB_SHORT_PERIODS 32768
`define CCS_STAB_LONG_PERIODS 131072
// sys_clk cycles per main oscillator period
`define CCS_CYC_PER_PERIOD 1

`endif

// ==== rtl/ccs_pkg.sv ====
// Purpose: Types shared by the CPU clock select block
// Assumes: Nothing
// Notes:   Constants live in ccs_defs.svh
package ccs_pkg;

    typedef enum logic {CCS_SRC_MAIN, CCS_SRC_SUB} ccs_src_t;

    typedef enum logic [1:0] {CCS_ST_WAIT, CCS_ST_RUN, CCS_ST_STOP} ccs_state_t;

endpackage

// ==== rtl/ccs_clk_div.sv ====
// Purpose: CPU clock period counter with a whole-period boundary pulse
// Assumes: limit only changes at a boundary or while cleared
// Notes:   cpu_clk is high for the first half of each period, except the first after clr, which starts one step low
`timescale 1ns/10ps

module ccs_clk_div
(
    input  wire logic       sys_clk,  // Main clock
    input  wire logic       sys_rst,  // Async reset, active high
    input  wire logic       clr,      // Hold counter at zero
    input  wire logic       adv,      // Advance one step
    input  wire logic [5:0] limit,    // Period length minus one
    output logic            bnd,      // Last step of a period
    output logic            cpu_clk   // CPU clock level
);

    logic [5:0] cnt;
    logic [5:0] next_cnt;

    assign bnd = adv && !clr && (cnt == limit);

    always_comb
    begin
        next_cnt = cnt;
        if (clr || bnd)
        begin
            next_cnt = 6'h00;
        end
        else if (adv)
        begin
            next_cnt = cnt + 6'h01;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt <= 6'h00;
        end
        else
        begin
            cnt <= next_cnt;
        end
    end

    // Period after a boundary starts high; the first period after clr starts low, its high pulse one step short
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cpu_clk <= 1'b0;
        end
        else
        begin
            cpu_clk <= !clr && (next_cnt <= {1'b0, limit[5:1]});
        end
    end

endmodule // ccs_clk_div

// ==== rtl/ccs_top.sv ====
// Purpose: CPU clock source and divider select, start-up wait, subsystem oscillator control
// Assumes: sys_clk is the main oscillator; stop_mode comes from logic on sys_clk
// Notes:   Registers reached over Avalon-MM, answer one cycle after the request
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "ccs_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Software picks main or subsystem oscillator as CPU clock source.
// - Divider code 00,01,10,11 gives main clock divided by 64,16,8,4.
// - Divider control register sits at address 0FB3 hex.
// - After reset wait 2^15 or 2^17 main periods, chosen at build time.
// - In stop mode the main oscillator input pin is not driven.
// - Subsystem control 00 selects low-voltage drive, 10 high-voltage low-current drive.
// - Lower subsystem control bit one switches the feedback resistor off.
// - Reset clears both subsystem control bits.
// - Build option switches the feedback resistor off permanently.
module ccs_top
#(
    parameter bit STAB_LONG_OPT   = 1'b1,  // Long start-up wait
    parameter bit FB_RES_OFF_OPT  = 1'b0,  // Feedback resistor removed
    parameter int STAB_SHORT_CYCLES = `CCS_STAB_SHORT_PERIODS * `CCS_CYC_PER_PERIOD,
    parameter int STAB_LONG_CYCLES  = `CCS_STAB_LONG_PERIODS * `CCS_CYC_PER_PERIOD
)
(
    input  wire logic        sys_clk,            // 20 MHz main clock
    input  wire logic        sys_rst,            // Async reset, active high
    input  wire logic [13:0] avs_address,        // Byte address
    input  wire logic        avs_read,           // Read request
    input  wire logic        avs_write,          // Write request
    input  wire logic [31:0] avs_writedata,      // Write data
    input  wire logic [3:0]  avs_byteenable,     // Byte lanes
    output logic      [31:0] avs_readdata,       // Read data
    output logic             avs_waitrequest,    // Stall
    input  wire logic        stop_mode,          // Stop mode request
    input  wire logic        sub_osc_input_pin,  // Subsystem clock pin
    input  wire logic        main_osc_in,        // Main pin level
    output logic             main_osc_out,       // Main pin drive value
    output logic             main_osc_oe_n,      // Main pin enable, low drives
    output logic             cpu_clk,            // CPU clock level
    output logic             cpu_cycle_pulse,    // End of CPU period
    output logic             cpu_reset,          // CPU held in reset
    output logic             sub_fb_res_en,      // Feedback resistor on
    output logic             sub_osc_hv_mode,    // High-voltage drive
    output logic             active_source       // 1 when on subsystem clock
);

    ccs_pkg::ccs_state_t state;
    ccs_pkg::ccs_src_t   clock_source_select;
    ccs_pkg::ccs_src_t   act_src;
    logic [1:0]  divider_select;
    logic [1:0]  act_div;
    logic [1:0]  subclock_osc_control;
    logic [17:0] stab_cnt;
    logic [17:0] stab_limit;
    logic        ack;
    logic        wr_fire;
    logic        req;
    logic [11:0] idx;
    logic [31:0] next_rdata;
    logic        sub_s1;
    logic        sub_s2;
    logic        sub_s3;
    logic        sub_lvl;
    logic        sub_edge;
    logic        main_s1;
    logic        main_s2;
    logic        main_s3;
    logic        main_lvl;
    logic        run;
    logic        adv;
    logic        bnd;
    logic [5:0]  limit;
    logic [6:0]  gap;

    assign stab_limit = 18'(STAB_LONG_OPT ? STAB_LONG_CYCLES - 1 : STAB_SHORT_CYCLES - 1);
    assign idx        = avs_address[13:2];
    assign req        = avs_read || avs_write;

    ////////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, then answer

    assign avs_waitrequest = req && !ack;
    assign wr_fire         = avs_write && ack && avs_byteenable[0];

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ack <= 1'b0;
        end
        else
        begin
            ack <= req && !ack;
        end
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (idx)
            `CCS_IDX_DIV:  next_rdata[1:0] = divider_select;
            `CCS_IDX_SRC:  next_rdata[0] = clock_source_select;
            `CCS_IDX_SOS:  next_rdata[1:0] = subclock_osc_control;
            `CCS_IDX_STAT:
            begin
                next_rdata[0]   = (state == ccs_pkg::CCS_ST_RUN);
                next_rdata[1]   = act_src;
                next_rdata[3:2] = act_div;
                next_rdata[4]   = (state == ccs_pkg::CCS_ST_STOP);
                next_rdata[5]   = main_lvl;
            end
            default:       next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (avs_read && !ack)
        begin
            avs_readdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            divider_select <= `CCS_DIV_RST;
        end
        else if (wr_fire && idx == `CCS_IDX_DIV)
        begin
            divider_select <= avs_writedata[1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clock_source_select <= ccs_pkg::CCS_SRC_MAIN;
        end
        else if (wr_fire && idx == `CCS_IDX_SRC)
        begin
            clock_source_select <= ccs_pkg::ccs_src_t'(avs_writedata[0]);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            subclock_osc_control <= `CCS_SOS_RST;
        end
        else if (wr_fire && idx == `CCS_IDX_SOS)
        begin
            subclock_osc_control <= avs_writedata[1:0];
        end
    end

    // Oscillator drive controls
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sub_fb_res_en   <= 1'b0;
            sub_osc_hv_mode <= 1'b0;
        end
        else
        begin
            sub_fb_res_en   <= !subclock_osc_control[`CCS_SOS_RES_OFF_BIT] && !FB_RES_OFF_OPT;
            sub_osc_hv_mode <= subclock_osc_control[`CCS_SOS_HV_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a change counts once stages two and three agree

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sub_s1   <= 1'b0;
            sub_s2   <= 1'b0;
            sub_s3   <= 1'b0;
            sub_lvl  <= 1'b0;
            sub_edge <= 1'b0;
            main_s1  <= 1'b0;
            main_s2  <= 1'b0;
            main_s3  <= 1'b0;
            main_lvl <= 1'b0;
        end
        else
        begin
            sub_s1   <= sub_osc_input_pin;
            sub_s2   <= sub_s1;
            sub_s3   <= sub_s2;
            sub_edge <= sub_s2 && sub_s3 && !sub_lvl;
            main_s1  <= main_osc_in;
            main_s2  <= main_s1;
            main_s3  <= main_s2;
            if (sub_s2 == sub_s3)
            begin
                sub_lvl <= sub_s2;
            end
            if (main_s2 == main_s3)
            begin
                main_lvl <= main_s2;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start-up wait and stop mode

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state    <= ccs_pkg::CCS_ST_WAIT;
            stab_cnt <= 18'h00000;
        end
        else
        begin
            case (state)
                ccs_pkg::CCS_ST_WAIT:
                begin
                    if (stab_cnt == stab_limit)
                    begin
                        state    <= ccs_pkg::CCS_ST_RUN;
                        stab_cnt <= 18'h00000;
                    end
                    else
                    begin
                        stab_cnt <= stab_cnt + 18'h00001;
                    end
                end
                ccs_pkg::CCS_ST_RUN:
                begin
                    if (stop_mode)
                    begin
                        state <= ccs_pkg::CCS_ST_STOP;
                    end
                end
                ccs_pkg::CCS_ST_STOP:
                begin
                    // Oscillator restarts, so wait again
                    if (!stop_mode)
                    begin
                        state <= ccs_pkg::CCS_ST_WAIT;
                    end
                end
                default:
                begin
                    state    <= ccs_pkg::CCS_ST_WAIT;
                    stab_cnt <= 18'h00000;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cpu_reset <= 1'b1;
        end
        else if (state == ccs_pkg::CCS_ST_WAIT && stab_cnt == stab_limit)
        begin
            cpu_reset <= 1'b0;
        end
    end

    // Main pin released in stop mode, bias drive otherwise
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            main_osc_oe_n <= 1'b1;
            main_osc_out  <= 1'b0;
        end
        else
        begin
            main_osc_oe_n <= stop_mode || state == ccs_pkg::CCS_ST_STOP;
            main_osc_out  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CPU clock

    assign run = (state == ccs_pkg::CCS_ST_RUN);
    assign adv = (act_src == ccs_pkg::CCS_SRC_SUB) ? sub_edge : 1'b1;

    always_comb
    begin
        limit = `CCS_LIM_DIV64;
        if (act_src == ccs_pkg::CCS_SRC_SUB)
        begin
            limit = `CCS_LIM_SUB;
        end
        else
        begin
            case (act_div)
                2'h0:    limit = `CCS_LIM_DIV64;
                2'h1:    limit = `CCS_LIM_DIV16;
                2'h2:    limit = `CCS_LIM_DIV8;
                2'h3:    limit = `CCS_LIM_DIV4;
                default: limit = `CCS_LIM_DIV64;
            endcase
        end
    end

    // Selections take effect only between whole CPU periods
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            act_src <= ccs_pkg::CCS_SRC_MAIN;
            act_div <= `CCS_DIV_RST;
        end
        else if (bnd || !run)
        begin
            act_src <= clock_source_select;
            act_div <= divider_select;
        end
    end

    ccs_clk_div u_div
    (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .clr     (!run),
        .adv     (adv),
        .limit   (limit),
        .bnd     (bnd),
        .cpu_clk (cpu_clk)
    );

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cpu_cycle_pulse <= 1'b0;
            active_source   <= 1'b0;
        end
        else
        begin
            cpu_cycle_pulse <= bnd;
            active_source   <= act_src;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Steps seen in the current period
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gap <= 7'h00;
        end
        else if (!run || bnd)
        begin
            gap <= 7'h00;
        end
        else if (adv)
        begin
            gap <= gap + 7'h01;
        end
    end

    AST_DIV_PERIOD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        bnd |-> gap == {1'b0, limit})
        else $error("CPU period length does not match selection");

    AST_DIV_MAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
        act_src == ccs_pkg::CCS_SRC_MAIN && act_div == 2'h1 |-> limit == 6'h0f)
        else $error("Divider code 01 is not divide by 16");

    AST_DIV_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 14'h3ecc
        |=> divider_select == $past(avs_writedata[1:0]))
        else $error("Divider register write at 0FB3 lost");

    AST_SRC_SWITCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
        run && bnd && clock_source_select != act_src |=> act_src == $past(clock_source_select))
        else $error("Source selection not applied at boundary");

    AST_SRC_BOUNDARY: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (act_src != $past(act_src) || act_div != $past(act_div)) |-> ($past(bnd) || !$past(run)))
        else $error("Clock selection changed inside a CPU period");

    AST_STAB_END: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(cpu_reset) |-> $past(stab_cnt) == stab_limit && $past(state) == ccs_pkg::CCS_ST_WAIT)
        else $error("CPU reset released before wait ended");

    AST_STAB_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cpu_reset |-> !cpu_cycle_pulse && stab_cnt <= stab_limit)
        else $error("CPU clocked during start-up wait");

    AST_STOP_HIZ: assert property (@(posedge sys_clk) disable iff (sys_rst)
        stop_mode |=> main_osc_oe_n)
        else $error("Main pin driven in stop mode");

    AST_HV_MODE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        subclock_osc_control == 2'h2 |=> sub_osc_hv_mode && (sub_fb_res_en == !FB_RES_OFF_OPT))
        else $error("High-voltage drive setting wrong");

    AST_FB_OFF: assert property (@(posedge sys_clk) disable iff (sys_rst)
        subclock_osc_control[0] |=> !sub_fb_res_en)
        else $error("Feedback resistor still on");

    AST_SOS_RESET: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $past(sys_rst) |-> subclock_osc_control == 2'h0 && !sub_osc_hv_mode)
        else $error("Subsystem control not cleared by reset");

    AST_FB_OPTION: assert property (@(posedge sys_clk) disable iff (sys_rst)
        FB_RES_OFF_OPT |-> !sub_fb_res_en)
        else $error("Feedback resistor on despite build option");

endmodule // ccs_top

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench for the CPU clock select block
// Assumes: Start-up wait shortened to 16/64 cycles; second instance has short wait and resistor option
// Notes:   Bus answers taken at the rising edge, other settled values sampled at falling edges
`timescale 1ns/10ps

module tb_top;

    localparam int STAB = 64;
    localparam logic [13:0] A_DIV  = 14'h3ecc;
    localparam logic [13:0] A_SRC  = 14'h3edc;
    localparam logic [13:0] A_STAT = 14'h3ee0;
    localparam logic [13:0] A_SOS  = 14'h3f3c;
    localparam logic [13:0] A_NONE = 14'h3ff0;

    logic        sys_clk;
    logic        sys_rst;
    logic [13:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        stop_mode;
    logic        sub_osc_input_pin = 1'b0;
    logic        main_osc_in;
    logic        main_osc_out;
    logic        main_osc_oe_n;
    logic        cpu_clk;
    logic        cpu_cycle_pulse;
    logic        cpu_reset;
    logic        sub_fb_res_en;
    logic        sub_osc_hv_mode;
    logic        active_source;
    logic        opt_cpu_reset;
    logic        opt_fb_res_en;
    logic        sub_run;
    logic [2:0]  sub_cnt = 3'h0;
    int          n_mismatch;
    int          checked;
    int          cyc = 0;

    ccs_top #(.STAB_LONG_OPT(1'b1), .FB_RES_OFF_OPT(1'b0), .STAB_SHORT_CYCLES(16), .STAB_LONG_CYCLES(STAB)) i_ccs_top
    (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode),
        .sub_osc_input_pin(sub_osc_input_pin), .main_osc_in(main_osc_in), .main_osc_out(main_osc_out),
        .main_osc_oe_n(main_osc_oe_n), .cpu_clk(cpu_clk), .cpu_cycle_pulse(cpu_cycle_pulse),
        .cpu_reset(cpu_reset), .sub_fb_res_en(sub_fb_res_en), .sub_osc_hv_mode(sub_osc_hv_mode),
        .active_source(active_source)
    );

    // Short wait and feedback resistor removed by build option
    ccs_top #(.STAB_LONG_OPT(1'b0), .FB_RES_OFF_OPT(1'b1), .STAB_SHORT_CYCLES(16), .STAB_LONG_CYCLES(STAB))
    i_ccs_top_opt
    (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(), .avs_waitrequest(), .stop_mode(stop_mode),
        .sub_osc_input_pin(sub_osc_input_pin), .main_osc_in(main_osc_in), .main_osc_out(),
        .main_osc_oe_n(), .cpu_clk(), .cpu_cycle_pulse(),
        .cpu_reset(opt_cpu_reset), .sub_fb_res_en(opt_fb_res_en), .sub_osc_hv_mode(),
        .active_source()
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Subsystem pin toggles every 8 cycles while enabled: a rising edge each 16 cycles
    always @(posedge sys_clk)
    begin
        sub_cnt <= sub_cnt + 3'h1;
        if (sub_run && sub_cnt == 3'h7)
            sub_osc_input_pin <= ~sub_osc_input_pin;
    end

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [13:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge sys_clk);
        avs_address   <= addr;
        avs_writedata <= wd;
        avs_read      <= ~wr;
        avs_write     <= wr;
        n = 0;
        // Waitrequest and read data are taken as they stood at each rising edge
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20)
            chk("bus answer", 32'h1, 32'h0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input string name, input logic [13:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(name, x, exp);
    endtask

    // Cycles from one CPU period pulse to the next
    task automatic period(output int p);
        int n;
        n = 0;
        do begin @(negedge sys_clk); n++; end while (cpu_cycle_pulse !== 1'b1 && n < 300);
        p = 0;
        do begin @(negedge sys_clk); p++; end while (cpu_cycle_pulse !== 1'b1 && p < 300);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        int n;
        int m;
        chk("oe_n in reset", main_osc_oe_n, 1'b1);
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        n = 0;
        m = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
            m += opt_cpu_reset;
        end
        while (cpu_reset === 1'b1 && n < 200);
        // Last step is the first one that sees the CPU released
        chk("start wait", n - 1, STAB);
        chk("short wait", m, 16);
        chk("fb res after reset", sub_fb_res_en, 1'b1);
        chk("fb res option", opt_fb_res_en, 1'b0);
        chk("hv after reset", sub_osc_hv_mode, 1'b0);
        chk("source after reset", active_source, 1'b0);
        chk("oe_n running", main_osc_oe_n, 1'b0);
        chk("pin drive value", main_osc_out, 1'b0);
        rd_chk("sos reset", A_SOS, 32'h0);
        rd_chk("div reset", A_DIV, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_regs();
        logic [1:0] v;
        for (int i = 0; i < 4; i++)
        begin
            v = i[1:0];
            wr(A_SOS, {30'h0, v});
            // Drive outputs follow the register one edge later
            repeat (2) @(negedge sys_clk);
            chk("hv mode", sub_osc_hv_mode, v[1]);
            chk("fb res", sub_fb_res_en, !v[0]);
            rd_chk("sos read", A_SOS, {30'h0, v});
        end
        avs_byteenable <= 4'h0;
        wr(A_SOS, 32'h0);
        avs_byteenable <= 4'hf;
        rd_chk("sos lane off", A_SOS, 32'h3);
        wr(A_SOS, 32'hffff_fff0);
        rd_chk("sos upper", A_SOS, 32'h0);
        wr(A_NONE, 32'hffff_ffff);
        rd_chk("unmapped", A_NONE, 32'h0);
        main_osc_in <= 1'b1;
        // Let the pin level pass the synchroniser
        repeat (4) @(posedge sys_clk);
        rd_chk("status", A_STAT, 32'h21);
        $display("test registers done");
    endtask

    task automatic t_div();
        int p;
        int exp[4] = '{64, 16, 8, 4};
        int old;
        old = 64;
        for (int k = 3; k >= 0; k--)
        begin
            wr(A_DIV, k); // codes 11, 10, 01 and 00 written in turn, each period checked
            period(p);
            if (p != old)
                chk("first period", p, exp[k]);
            period(p);
            chk("cpu period", p, exp[k]);
            rd_chk("div read", A_DIV, k);
            old = exp[k];
        end
        $display("test divider done");
    endtask

    task automatic t_src();
        int n;
        int p;
        wr(A_SOS, 32'h1);
        wr(A_DIV, 32'h3);
        sub_run <= 1'b1;
        wr(A_SRC, 32'h1);
        n = 0;
        do begin @(negedge sys_clk); n++; end while (active_source !== 1'b1 && n < 300);
        chk("on sub", active_source, 1'b1);
        chk("fb res ext clk", sub_fb_res_en, 1'b0);
        period(p);
        chk("sub period", p, 64);
        rd_chk("status sub", A_STAT, 32'h2f);
        wr(A_SRC, 32'h0);
        n = 0;
        do begin @(negedge sys_clk); n++; end while (active_source !== 1'b0 && n < 300);
        chk("on main", active_source, 1'b0);
        sub_run <= 1'b0;
        period(p);
        chk("main period", p, 4);
        $display("test source done");
    endtask

    task automatic t_stop();
        int n;
        @(posedge sys_clk);
        stop_mode <= 1'b1;
        @(negedge sys_clk);
        @(negedge sys_clk);
        chk("oe_n stop", main_osc_oe_n, 1'b1);
        n = 0;
        repeat (20)
        begin
            @(negedge sys_clk);
            n += cpu_cycle_pulse;
        end
        chk("no pulse in stop", n, 0);
        chk("clk in stop", cpu_clk, 1'b0);
        rd_chk("status stop", A_STAT, 32'h3c);
        @(posedge sys_clk);
        stop_mode <= 1'b0;
        n = 0;
        do begin @(negedge sys_clk); n++; end while (cpu_cycle_pulse !== 1'b1 && n < 300);
        chk("restart late", n > STAB, 1'b1);
        chk("reset kept low", cpu_reset, 1'b0);
        chk("oe_n after stop", main_osc_oe_n, 1'b0);
        $display("test stop done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        n_mismatch = 0;
        checked = 0;
        sys_rst = 1'b1;
        avs_address = 14'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        stop_mode = 1'b0;
        main_osc_in = 1'b0;
        sub_run = 1'b0;
        repeat (5) @(posedge sys_clk);
        t_reset();
        t_regs();
        t_div();
        t_src();
        t_stop();
        results();
    end

endmodule // tb_top
